// file: rim_regs.svh
`ifndef RIM_REGS_SVH
`define RIM_REGS_SVH

// spi word layout: bit 15 selects write, bits 14:8 carry the byte address
`define RIM_SPI_BITS      16
`define RIM_SPI_WR_BIT    15
`define RIM_SPI_ADDR_MSB  14
`define RIM_SPI_ADDR_LSB  8

// byte addresses of the even (low) byte of each 16-bit register
`define RIM_ADDR_X_PEAK   7'h46
`define RIM_ADDR_Y_PEAK   7'h48
`define RIM_ADDR_Z_PEAK   7'h4a
`define RIM_ADDR_USER_ID  7'h5a
`define RIM_ADDR_WEAR     7'h5c
`define RIM_ADDR_MISC     7'h64
`define RIM_ADDR_INFO1    7'h66
`define RIM_ADDR_INFO2    7'h68
`define RIM_ADDR_RCOUNT   7'h6a
`define RIM_ADDR_X_BIN    7'h6c
`define RIM_ADDR_Y_BIN    7'h6e
`define RIM_ADDR_Z_BIN    7'h70

// miscellaneous control bit positions
`define RIM_MISC_TRIG_EN  12
`define RIM_MISC_STAT_LD  10
`define RIM_MISC_STAT_SV  9
`define RIM_MISC_STAT_CLR 8
`define RIM_MISC_ST_ON    3
`define RIM_MISC_ST_OFF   2

// record information fields
`define RIM_INFO1_RATE_LSB 14
`define RIM_INFO1_WIN_LSB  12

// reset values and record storage geometry
`define RIM_MISC_RST      16'h0000
`define RIM_INFO_RST      16'h0000
`define RIM_RCOUNT_RST    4'h0
`define RIM_RECORD_LAST   4'h9

`endif

// file: rim_pkg.sv
package rim_pkg;

  // nonvolatile port sequencer, one-hot
  typedef enum logic [2:0] {
    RIM_NV_IDLE  = 3'b001,
    RIM_NV_LOAD  = 3'b010,
    RIM_NV_STORE = 3'b100
  } rim_nv_state_type;

  // image kept in nonvolatile storage
  typedef struct packed {
    logic [15:0] wear;
    logic [15:0] user_id;
  } rim_nv_image_type;

  typedef struct packed {
    logic        sclk;
    logic        cs_n;
    logic [3:0]  count;
    logic [15:0] shift_in;
    logic [15:0] shift_out;
    logic        dout;
    logic        valid;
    logic [15:0] rx;
  } rim_spi_state_type;

  typedef struct packed {
    rim_nv_state_type fsm;
    logic             pending;
    logic             load_done;
    rim_nv_image_type wdata;
    rim_nv_image_type restored;
  } rim_nv_fsm_type;

  typedef struct packed {
    logic [15:0]        user_id;
    logic [15:0]        wear;
    logic               trig_en;
    logic               selftest;
    logic               stat_load;
    logic               stat_save;
    logic               stat_clear;
    logic               sync;
    logic               capture;
    logic               nv_store;
    logic [1:0]         rate;
    logic [1:0]         window;
    logic [7:0]         averages;
    logic [3:0]         avg_setting;
    logic [3:0]         rcount;
    logic [2:0][11:0]   bin;
    logic [2:0][15:0]   peak;
    logic [15:0]        tx;
  } rim_core_state_type;

endpackage

// file: rim_if.sv
`timescale 1ns/1ps

// one received spi word and the word to send in the next frame
interface rim_word_if;
  logic        word_valid;
  logic [15:0] rx_word;
  logic [15:0] tx_word;
  modport spi  (output word_valid, output rx_word, input tx_word);
  modport core (input word_valid, input rx_word, output tx_word);
endinterface

// store requests and restore results between core and nonvolatile port
interface rim_nv_if;
  logic                      store_req;
  rim_pkg::rim_nv_image_type image;
  logic                      load_done;
  rim_pkg::rim_nv_image_type restored;
  modport core (output store_req, output image, input load_done, input restored);
  modport port (input store_req, input image, output load_done, output restored);
endinterface

// file: rim_spi_slave.sv
`timescale 1ns/1ps

module rim_spi_slave
(
  // clock and reset
  input  wire logic core_clk_i,
  input  wire logic rst_i,
  // serial pins, sampled as synchronous inputs
  input  wire logic spi_cs_n_i,
  input  wire logic spi_sclk_i,
  input  wire logic spi_din_i,
  output logic      spi_dout_o,
  // word side
  rim_word_if.spi   word
);
  import rim_pkg::*;

  rim_spi_state_type q;
  rim_spi_state_type d;

  ////////////////////////////////////////////////////////////////////////////////
  // clock idles high: sample on rising sclk, shift out on falling sclk
  always_comb
  begin
    d        = q;
    d.valid  = 1'b0;
    d.sclk   = spi_sclk_i;
    d.cs_n   = spi_cs_n_i;
    if (spi_cs_n_i)
    begin
      d.count = 4'h0; // a broken frame is dropped, never half-taken
    end
    else if (q.cs_n)
    begin
      d.shift_out = word.tx_word; // reply word is frozen at frame start
      d.count     = 4'h0;
    end
    else
    begin
      if (!q.sclk && spi_sclk_i)
      begin
        d.shift_in = {q.shift_in[14:0], spi_din_i};
        d.count    = q.count + 4'h1;
        if (q.count == 4'hf)
        begin
          d.valid = 1'b1;
          d.rx    = {q.shift_in[14:0], spi_din_i};
        end
      end
      if (q.sclk && !spi_sclk_i)
      begin
        d.dout      = q.shift_out[15];
        d.shift_out = {q.shift_out[14:0], 1'b0};
      end
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      q <= '{sclk: 1'b1, cs_n: 1'b1, default: '0};
    else
      q <= d;
  end

  assign spi_dout_o      = q.dout;
  assign word.word_valid = q.valid;
  assign word.rx_word    = q.rx;
endmodule

// file: rim_nv_port.sv
`timescale 1ns/1ps

module rim_nv_port
(
  // clock and reset
  input  wire logic                      core_clk_i,
  input  wire logic                      rst_i,
  // nonvolatile store handshake
  output logic                           nv_req_o,
  output logic                           nv_write_o,
  output rim_pkg::rim_nv_image_type      nv_wdata_o,
  input  wire rim_pkg::rim_nv_image_type nv_rdata_i,
  input  wire logic                      nv_ack_i,
  // core side
  rim_nv_if.port                         nv
);
  import rim_pkg::*;

  rim_nv_fsm_type q;
  rim_nv_fsm_type d;

  ////////////////////////////////////////////////////////////////////////////////
  // restore once after reset, then store each new image; a request seen while
  // busy is parked so the image current when the port goes idle reaches storage
  always_comb
  begin
    d           = q;
    d.load_done = 1'b0;
    if (nv.store_req)
      d.pending = 1'b1;
    unique case (q.fsm)
      RIM_NV_LOAD:
      begin
        if (nv_ack_i)
        begin
          d.restored  = nv_rdata_i;
          d.load_done = 1'b1;
          d.fsm       = RIM_NV_IDLE;
        end
      end
      RIM_NV_IDLE:
      begin
        if (q.pending || nv.store_req)
        begin
          d.wdata   = nv.image;
          d.pending = 1'b0;
          d.fsm     = RIM_NV_STORE;
        end
      end
      RIM_NV_STORE:
      begin
        if (nv_ack_i)
          d.fsm = RIM_NV_IDLE;
      end
      default:
      begin
        d.fsm = RIM_NV_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      q <= '{fsm: RIM_NV_LOAD, default: '0};
    else
      q <= d;
  end

  assign nv_req_o     = (q.fsm != RIM_NV_IDLE);
  assign nv_write_o   = (q.fsm == RIM_NV_STORE);
  assign nv_wdata_o   = q.wdata;
  assign nv.load_done = q.load_done;
  assign nv.restored  = q.restored;
endmodule

// file: rim_regs_top.sv
// How it works
// - 16-bit user id is read/write and restored from nonvolatile storage after reset
// - wear counter increments when the global command clears user records
// - wear counter also increments when the tenth record location fills
// - control bit 12 lets the sync pin start a capture
// - writing bit 10 loads statistics from flash; host sets record pointer first
// - writing bit 9 saves statistics from sram into a flash record
// - writing bit 8 clears accumulated time-domain statistics
// - bit 3 turns self-test on, bit 2 turns it off
// - control register resets to zero and is never restored
// - first info register bits 15:14 report sample rate option
// - bits 13:12 report window: rectangular, hanning, flat top
// - bits 7:0 report number of fft averages
// - info registers only meaningful for fft capture results
// - second info register bits 3:0 copy averaging count setting
// - records-in-use count in bits 3:0, 0 to 9, resets to zero
// - x alarm bin register holds peak fft bin in bits 11:0
// - y alarm bin register holds peak fft bin in bits 11:0
// - z alarm bin register holds peak fft bin in bits 11:0
// - each axis peak register holds magnitude of its alarm bin
`timescale 1ns/1ps
`include "rim_regs.svh"

module rim_regs_top
#(
  parameter int AXES = 3
)
(
  // clock and reset
  input  wire logic                      core_clk_i,
  input  wire logic                      rst_i,
  // host serial port
  input  wire logic                      spi_cs_n_i,
  input  wire logic                      spi_sclk_i,
  input  wire logic                      spi_din_i,
  output logic                           spi_dout_o,
  // nonvolatile store
  output logic                           nv_req_o,
  output logic                           nv_write_o,
  output rim_pkg::rim_nv_image_type      nv_wdata_o,
  input  wire rim_pkg::rim_nv_image_type nv_rdata_i,
  input  wire logic                      nv_ack_i,
  // record storage events
  input  wire logic                      records_cleared_i,
  input  wire logic                      record_stored_i,
  // spectral record results
  input  wire logic                      spectral_done_i,
  input  wire logic                      spectral_mode_i,
  input  wire logic [1:0]                sample_rate_option_i,
  input  wire logic [1:0]                window_i,
  input  wire logic [7:0]                fft_averages_i,
  input  wire logic [3:0]                averaging_count_setting_i,
  // alarm results, axis 0 = x in the low lanes
  input  wire logic                      alarm_update_i,
  input  wire logic [AXES*12-1:0]        alarm_bin_i,
  input  wire logic [AXES*16-1:0]        alarm_peak_i,
  // external trigger
  input  wire logic                      sync_pin_i,
  // control outputs
  output logic                           ext_trigger_enable_o,
  output logic                           capture_start_o,
  output logic                           stat_load_o,
  output logic                           stat_save_o,
  output logic                           stat_clear_o,
  output logic                           selftest_on_o
);
  import rim_pkg::*;

  rim_word_if word ();
  rim_nv_if   nvl  ();

  rim_core_state_type q;
  rim_core_state_type d;

  logic [AXES-1:0][11:0] bin_in;
  logic [AXES-1:0][15:0] peak_in;

  ////////////////////////////////////////////////////////////////////////////////
  // serial port and nonvolatile sequencer

  rim_spi_slave u_spi
  (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .spi_cs_n_i (spi_cs_n_i),
    .spi_sclk_i (spi_sclk_i),
    .spi_din_i  (spi_din_i),
    .spi_dout_o (spi_dout_o),
    .word       (word.spi)
  );

  rim_nv_port u_nv
  (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .nv_req_o   (nv_req_o),
    .nv_write_o (nv_write_o),
    .nv_wdata_o (nv_wdata_o),
    .nv_rdata_i (nv_rdata_i),
    .nv_ack_i   (nv_ack_i),
    .nv         (nvl.port)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // split the flat alarm inputs into per-axis lanes

  for (genvar a = 0; a < AXES; a++)
  begin : g_axis
    assign bin_in[a]  = alarm_bin_i[a*12 +: 12];
    assign peak_in[a] = alarm_peak_i[a*16 +: 16];
  end

  ////////////////////////////////////////////////////////////////////////////////
  // register read view; bits outside each field read as zero

  function automatic logic [15:0] read_word(input rim_core_state_type s,
                                            input logic [6:0]         addr);
    logic [15:0] r;
    r = 16'h0000;
    unique case ({addr[6:1], 1'b0})
      `RIM_ADDR_USER_ID: r = s.user_id;
      `RIM_ADDR_WEAR:    r = s.wear;
      `RIM_ADDR_MISC:    r[`RIM_MISC_TRIG_EN] = s.trig_en;
      `RIM_ADDR_INFO1:   r = {s.rate, s.window, 4'h0, s.averages};
      `RIM_ADDR_INFO2:   r = {12'h000, s.avg_setting};
      `RIM_ADDR_RCOUNT:  r = {12'h000, s.rcount};
      `RIM_ADDR_X_BIN:   r = {4'h0, s.bin[0]};
      `RIM_ADDR_Y_BIN:   r = {4'h0, s.bin[1]};
      `RIM_ADDR_Z_BIN:   r = {4'h0, s.bin[2]};
      `RIM_ADDR_X_PEAK:  r = s.peak[0];
      `RIM_ADDR_Y_PEAK:  r = s.peak[1];
      `RIM_ADDR_Z_PEAK:  r = s.peak[2];
      default:           r = 16'h0000; // unmapped addresses read zero
    endcase
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // next-state logic for the whole register slice

  always_comb
  begin
    logic        wr;
    logic        hi;
    logic [6:0]  addr;
    logic [7:0]  data;
    logic [15:0] wr_word;
    logic        wear_inc;
    logic [15:0] wear_base;

    wr        = 1'b0;
    hi        = 1'b0;
    addr      = 7'h00;
    data      = 8'h00;
    wr_word   = 16'h0000;
    wear_inc  = 1'b0;
    wear_base = 16'h0000;

    d            = q;
    d.stat_load  = 1'b0;
    d.stat_save  = 1'b0;
    d.stat_clear = 1'b0;
    d.capture    = 1'b0;
    d.nv_store   = 1'b0;
    d.sync       = sync_pin_i;

    // decode one host word: byte writes land in the lane picked by address bit 0
    addr    = word.rx_word[`RIM_SPI_ADDR_MSB:`RIM_SPI_ADDR_LSB];
    data    = word.rx_word[7:0];
    wr      = word.word_valid && word.rx_word[`RIM_SPI_WR_BIT];
    hi      = addr[0];
    wr_word = hi ? {data, 8'h00} : {8'h00, data};

    // a read is answered in the next frame; a write leaves a zero reply
    if (word.word_valid)
      d.tx = wr ? 16'h0000 : read_word(q, addr);

    // user id: byte write, then the new image is queued for storage
    if (wr && {addr[6:1], 1'b0} == `RIM_ADDR_USER_ID)
    begin
      if (hi)
        d.user_id[15:8] = data;
      else
        d.user_id[7:0] = data;
      d.nv_store = 1'b1;
    end

    // control: bit 12 is kept, action bits only pulse and read back as zero
    if (wr && {addr[6:1], 1'b0} == `RIM_ADDR_MISC)
    begin
      if (hi)
        d.trig_en = wr_word[`RIM_MISC_TRIG_EN];
      d.stat_load  = wr_word[`RIM_MISC_STAT_LD];
      d.stat_save  = wr_word[`RIM_MISC_STAT_SV];
      d.stat_clear = wr_word[`RIM_MISC_STAT_CLR];
      // turning on wins if the host sets both bits in one write
      if (wr_word[`RIM_MISC_ST_ON])
        d.selftest = 1'b1;
      else if (wr_word[`RIM_MISC_ST_OFF])
        d.selftest = 1'b0;
    end

    // external trigger: rising sync edge starts a capture only when enabled
    d.capture = q.trig_en && sync_pin_i && !q.sync;

    // record usage: a clear empties storage, the tenth store wraps it
    if (records_cleared_i)
    begin
      d.rcount = `RIM_RCOUNT_RST;
      wear_inc = 1'b1;
    end
    else if (record_stored_i)
    begin
      if (q.rcount == `RIM_RECORD_LAST)
      begin
        d.rcount = `RIM_RCOUNT_RST;
        wear_inc = 1'b1;
      end
      else
      begin
        d.rcount = q.rcount + 4'h1;
      end
    end

    // restore overrides the live values once, yet an event in that cycle still counts
    if (nvl.load_done)
    begin
      wear_base = nvl.restored.wear;
      if (!(wr && {addr[6:1], 1'b0} == `RIM_ADDR_USER_ID))
        d.user_id = nvl.restored.user_id;
    end
    else
    begin
      wear_base = q.wear;
    end
    d.wear = wear_base + {15'h0000, wear_inc};
    if (wear_inc)
      d.nv_store = 1'b1;

    // spectral results are latched only from fft capture modes
    if (spectral_done_i && spectral_mode_i)
    begin
      d.rate        = sample_rate_option_i;
      d.window      = window_i;
      d.averages    = fft_averages_i;
      d.avg_setting = averaging_count_setting_i;
    end

    // alarm bin and its magnitude always move together per axis
    if (alarm_update_i)
    begin
      for (int a = 0; a < AXES; a++)
      begin
        d.bin[a]  = bin_in[a];
        d.peak[a] = peak_in[a];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // state register; control starts cleared and nothing of it is ever restored

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      q             <= '0;
      q.trig_en     <= `RIM_MISC_RST == 16'h0000 ? 1'b0 : 1'b1;
      q.rcount      <= `RIM_RCOUNT_RST;
      q.averages    <= 8'h00;
    end
    else
    begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs

  assign word.tx_word         = q.tx;
  assign nvl.store_req        = q.nv_store; // image below is already updated
  assign nvl.image            = '{wear: q.wear, user_id: q.user_id};
  assign ext_trigger_enable_o = q.trig_en;
  assign capture_start_o      = q.capture;
  assign stat_load_o          = q.stat_load;
  assign stat_save_o          = q.stat_save;
  assign stat_clear_o         = q.stat_clear;
  assign selftest_on_o        = q.selftest;
endmodule

// file: rim_regs_properties.sv
`timescale 1ns/1ps

module rim_regs_properties
(
  // clock and reset
  input wire logic                      core_clk_i,
  input wire logic                      rst_i,
  // watched pins
  input wire logic                      spi_cs_n_i,
  input wire logic                      sync_pin_i,
  input wire logic                      nv_req_o,
  input wire logic                      nv_write_o,
  input wire rim_pkg::rim_nv_image_type nv_wdata_o,
  input wire logic                      nv_ack_i,
  input wire logic                      ext_trigger_enable_o,
  input wire logic                      capture_start_o,
  input wire logic                      stat_load_o,
  input wire logic                      stat_save_o,
  input wire logic                      stat_clear_o,
  input wire logic                      selftest_on_o
);
  import rim_pkg::*;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  // any statistics action pulse
  logic any_stat;
  assign any_stat = stat_load_o | stat_save_o | stat_clear_o;

  ////////////////////////////////////////////////////////////////////////////////
  a_capture_when_armed: assert property (
    ($rose(sync_pin_i) && ext_trigger_enable_o) |-> ##[1:3] capture_start_o)
    else $error("no capture after armed trigger edge");
  a_capture_needs_arm: assert property (
    capture_start_o |-> $past(ext_trigger_enable_o))
    else $error("capture while trigger disabled");
  a_capture_single: assert property (
    capture_start_o |=> !capture_start_o)
    else $error("capture pulse longer than one cycle");
  a_stat_single: assert property (
    any_stat |=> !any_stat)
    else $error("statistics pulse longer than one cycle");
  // control effects only ever follow a word taken inside a select frame
  a_ctrl_from_frame: assert property (
    ($changed(selftest_on_o) || $changed(ext_trigger_enable_o) || $rose(any_stat))
    |-> !$past(spi_cs_n_i))
    else $error("control output moved outside a frame");
  a_load_after_reset: assert property (
    $fell(rst_i) |-> (nv_req_o && !nv_write_o))
    else $error("no restore request after reset");
  a_load_ack_ends: assert property (
    (nv_ack_i && nv_req_o && !nv_write_o) |=> !nv_req_o)
    else $error("restore request held after ack");
  a_store_data_stable: assert property (
    (nv_req_o && nv_write_o && $past(nv_req_o) && $past(nv_write_o) && !$past(nv_ack_i))
    |-> $stable(nv_wdata_o))
    else $error("store image moved while pending");

  // main scenarios reached
  c_capture: cover property (capture_start_o);
  c_store: cover property (nv_req_o && nv_write_o && nv_ack_i);
  c_stat_load: cover property (stat_load_o);
endmodule

bind rim_regs_top rim_regs_properties u_rim_regs_properties (.*);

// file: rim_host_model.sv
`timescale 1ns/1ps

module rim_host_model
(
  // clock
  input  wire logic core_clk_i,
  // serial pins
  output logic      spi_cs_n_o,
  output logic      spi_sclk_o,
  output logic      spi_din_o,
  input  wire logic spi_dout_i
);
  // half sclk period in core clocks; the device needs at least two
  localparam int HALF = 4;

  initial
  begin
    spi_cs_n_o = 1'b1;
    spi_sclk_o = 1'b1;
    spi_din_o  = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // one word per frame, msb first; reply is sampled on each sclk rise
  task automatic xfer(input logic [15:0] word, output logic [15:0] reply);
    @(posedge core_clk_i);
    #2 spi_cs_n_o = 1'b0;
    for (int i = 15; i >= 0; i--)
    begin
      repeat (HALF) @(posedge core_clk_i);
      #2 spi_sclk_o = 1'b0;
      spi_din_o = word[i];
      repeat (HALF) @(posedge core_clk_i);
      #2 spi_sclk_o = 1'b1;
      reply[i] = spi_dout_i;
    end
    // long tail so the word lands well before select rises
    repeat (2 * HALF) @(posedge core_clk_i);
    #2 spi_cs_n_o = 1'b1;
    spi_din_o = ~spi_din_o; // released line must not look like the last bit
    repeat (HALF) @(posedge core_clk_i);
    #2;
  endtask
endmodule

// file: rim_regs_tb.sv
`timescale 1ns/1ps
`include "rim_regs.svh"

module rim_regs_tb;
  import rim_pkg::*;

  // pins
  logic             core_clk_i, rst_i, spi_cs_n_i, spi_sclk_i, spi_din_i, spi_dout_o;
  logic             nv_req_o, nv_write_o, nv_ack_i, records_cleared_i, record_stored_i;
  logic             spectral_done_i, spectral_mode_i, alarm_update_i, sync_pin_i;
  logic             ext_trigger_enable_o, capture_start_o, selftest_on_o;
  logic             stat_load_o, stat_save_o, stat_clear_o;
  rim_nv_image_type nv_wdata_o, nv_rdata_i, nv_mem;
  logic [1:0]       sample_rate_option_i, window_i;
  logic [7:0]       fft_averages_i;
  logic [3:0]       averaging_count_setting_i;
  logic [35:0]      alarm_bin_i;
  logic [47:0]      alarm_peak_i;
  // bench state
  logic [31:0]      rng = 32'h649e;
  logic [31:0]      v;
  logic [15:0]      n_cap, n_load, n_save, n_clr, wear, e1;
  int               num_errors, checks_done;

  // every top port has a bench signal of the same name
  rim_regs_top u_rim_regs_top (.*);

  rim_host_model u_rim_host_model (.core_clk_i(core_clk_i), .spi_cs_n_o(spi_cs_n_i),
    .spi_sclk_o(spi_sclk_i), .spi_din_o(spi_din_i), .spi_dout_i(spi_dout_o));

  initial
  begin
    core_clk_i = 1'b0;
    forever #25 core_clk_i = ~core_clk_i;
  end

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] nxt();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction

  // expected first record information word
  function automatic logic [15:0] info1_exp(input logic [1:0] r, input logic [1:0] w,
                                            input logic [7:0] a);
    return {r, w, 4'h0, a};
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    checks_done++;
    if (seen !== want)
    begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  // read takes two frames: the reply arrives in the frame after the command
  task automatic rd(input logic [6:0] a, input logic [15:0] want);
    logic [15:0] r;
    u_rim_host_model.xfer({1'b0, a, 8'h00}, r);
    u_rim_host_model.xfer(16'h0000, r);
    check(r, want);
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [15:0] r;
    u_rim_host_model.xfer({1'b1, a, d}, r);
  endtask

  task automatic strobe(ref logic s);
    @(posedge core_clk_i);
    #2 s = 1'b1;
    @(posedge core_clk_i);
    #2 s = 1'b0;
    repeat (4) @(posedge core_clk_i);
    #2;
  endtask

  task automatic do_reset();
    rst_i = 1'b1;
    repeat (12) @(posedge core_clk_i);
    #2 rst_i = 1'b0;
    repeat (20) @(posedge core_clk_i);
    #2;
  endtask

  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // nonvolatile store: answers every request after three cycles, data valid with ack only
  initial
  begin
    nv_ack_i = 1'b0;
    nv_rdata_i = '0;
    forever
    begin
      @(posedge core_clk_i);
      #2;
      if (nv_req_o === 1'b1 && rst_i === 1'b0)
      begin
        repeat (3) @(posedge core_clk_i);
        #2;
        if (nv_write_o)
          nv_mem = nv_wdata_o;
        nv_rdata_i = nv_mem;
        nv_ack_i = 1'b1;
        @(posedge core_clk_i);
        #2 nv_ack_i = 1'b0;
        nv_rdata_i = ~nv_mem;
      end
    end
  end

  // count action pulses seen at the outputs
  always @(posedge core_clk_i)
  begin
    n_cap  <= n_cap + {15'h0, capture_start_o};
    n_load <= n_load + {15'h0, stat_load_o};
    n_save <= n_save + {15'h0, stat_save_o};
    n_clr  <= n_clr + {15'h0, stat_clear_o};
  end

  // a hang is cut short well beyond the expected run of about 14000 cycles
  initial
  begin
    repeat (60000) @(posedge core_clk_i);
    num_errors++;
    tally_and_finish();
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {n_cap, n_load, n_save, n_clr} = '0;
    {records_cleared_i, record_stored_i, spectral_done_i, spectral_mode_i} = 4'h0;
    {alarm_update_i, sync_pin_i, sample_rate_option_i, window_i} = 6'h00;
    {fft_averages_i, averaging_count_setting_i, alarm_bin_i, alarm_peak_i} = '0;
    nv_mem = nxt();
    wear = nv_mem.wear;
    do_reset();
    rd(`RIM_ADDR_USER_ID, nv_mem.user_id);
    rd(`RIM_ADDR_WEAR, wear);
    rd(`RIM_ADDR_MISC, 16'h0000);
    rd(`RIM_ADDR_RCOUNT, 16'h0000);
    rd(`RIM_ADDR_INFO1, 16'h0000);
    $display("test reset_values done");
    // user id survives a second reset, control does not
    v = nxt();
    wr(`RIM_ADDR_USER_ID, v[7:0]);
    wr(`RIM_ADDR_USER_ID + 7'h1, v[15:8]);
    wr(`RIM_ADDR_MISC + 7'h1, 8'h10);
    rd(`RIM_ADDR_USER_ID, v[15:0]);
    do_reset();
    rd(`RIM_ADDR_USER_ID, v[15:0]);
    rd(`RIM_ADDR_MISC, 16'h0000);
    check({15'h0, ext_trigger_enable_o}, 16'h0000);
    wr(`RIM_ADDR_WEAR, 8'hff);
    rd(`RIM_ADDR_WEAR, wear);
    $display("test user_id done");
    // wear counter: global clear, then ten stores fill the record space
    strobe(records_cleared_i);
    rd(`RIM_ADDR_WEAR, wear + 16'h1);
    repeat (9) strobe(record_stored_i);
    rd(`RIM_ADDR_RCOUNT, 16'h0009);
    strobe(record_stored_i);
    rd(`RIM_ADDR_RCOUNT, 16'h0000);
    rd(`RIM_ADDR_WEAR, wear + 16'h2);
    $display("test wear done");
    // external trigger armed, then disarmed
    wr(`RIM_ADDR_MISC + 7'h1, 8'h10);
    check({15'h0, ext_trigger_enable_o}, 16'h0001);
    strobe(sync_pin_i);
    check(n_cap, 16'h0001);
    rd(`RIM_ADDR_MISC, 16'h1000);
    wr(`RIM_ADDR_MISC + 7'h1, 8'h00);
    strobe(sync_pin_i);
    check(n_cap, 16'h0001);
    // statistics actions one bit at a time: clear, save, load
    for (int k = 0; k < 3; k++)
      wr(`RIM_ADDR_MISC + 7'h1, 8'h01 << k);
    check(n_clr, 16'h0001);
    check(n_save, 16'h0001);
    check(n_load, 16'h0001);
    wr(`RIM_ADDR_MISC, 8'h08);
    check({15'h0, selftest_on_o}, 16'h0001);
    wr(`RIM_ADDR_MISC, 8'h04);
    check({15'h0, selftest_on_o}, 16'h0000);
    $display("test control done");
    // record info: a corner record first, then random ones
    for (int k = 0; k < 5; k++)
    begin
      v = (k == 0) ? 32'hffff_ffff : nxt();
      {sample_rate_option_i, fft_averages_i, averaging_count_setting_i} = v[13:0];
      window_i = (k == 0) ? 2'b10 : 2'(v[31:16] % 3);
      spectral_mode_i = 1'b1;
      strobe(spectral_done_i);
      e1 = info1_exp(sample_rate_option_i, window_i, fft_averages_i);
      rd(`RIM_ADDR_INFO1, e1);
      rd(`RIM_ADDR_INFO2, {12'h000, averaging_count_setting_i});
    end
    spectral_mode_i = 1'b0;
    {sample_rate_option_i, fft_averages_i} = ~{sample_rate_option_i, fft_averages_i};
    strobe(spectral_done_i);
    rd(`RIM_ADDR_INFO1, e1);
    $display("test record_info done");
    // alarm bins and peaks, first round at the top bin
    for (int k = 0; k < 3; k++)
    begin
      for (int a = 0; a < 3; a++)
      begin
        v = nxt();
        alarm_bin_i[a*12 +: 12] = (k == 0) ? 12'h7ff : {1'b0, v[10:0]};
        alarm_peak_i[a*16 +: 16] = v[31:16];
      end
      strobe(alarm_update_i);
      for (int a = 0; a < 3; a++)
      begin
        rd(`RIM_ADDR_X_BIN + 7'(2 * a), {4'h0, alarm_bin_i[a*12 +: 12]});
        rd(`RIM_ADDR_X_PEAK + 7'(2 * a), alarm_peak_i[a*16 +: 16]);
      end
    end
    rd(7'h30, 16'h0000);
    $display("test alarms done");
    tally_and_finish();
  end
endmodule
